// >>> rtl/sirq_pkg.sv
/*
 * sirq_pkg: shared types and constants of the serial interrupt slave.
 * assumes: included by the slave module through a wildcard import.
 */

package sirq_pkg;

    // ************************************************************
    // states and phases
    // ************************************************************
    typedef enum logic [4:0] {
        ST_IDLE  = 5'h01,
        ST_START = 5'h02,
        ST_FRAME = 5'h04,
        ST_STOP  = 5'h08,
        ST_POST  = 5'h10
    } sirq_state_t;

    typedef enum logic [2:0] {
        PH_SAMPLE = 3'h1,
        PH_RECOV  = 3'h2,
        PH_TURN   = 3'h4
    } sirq_phase_t;

    // ************************************************************
    // second management-interrupt enable register image
    // ************************************************************
    typedef struct packed {
        logic       pin_en;     // bit 7
        logic       serial_en;  // bit 6
        logic [5:0] other;      // bits 5..0, not used here
    } sirq_smi_en2_t;

    // ************************************************************
    // frame numbering and stop widths
    // ************************************************************
    localparam logic [5:0]  SIRQ_FRAME_FIRST = 6'h02;
    localparam logic [5:0]  SIRQ_FRAME_LAST  = 6'h10;
    localparam logic [5:0]  SIRQ_FRAME_MAX   = 6'h3F;
    localparam logic [2:0]  SIRQ_STOP_QUIET  = 3'h2;
    localparam logic [2:0]  SIRQ_LOW_MAX     = 3'h7;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic        SIRQ_RST_QUIET   = 1'b0;
    localparam logic [15:0] SIRQ_RST_LEVEL   = 16'hFFFF;

endpackage

// >>> rtl/sirq_slave.sv
/*
 * sirq_slave: slave agent of the serialized interrupt wire.
 * Reports fifteen interrupt levels and the management interrupt
 * in their frames, starts cycles in quiet mode on a level change
 * and follows the mode chosen by each stop pulse width.
 * assumes: mclk is the bus clock that the host also uses; the wire
 * is open-drain with a pull-up resolved outside; rst is the bus reset.
 */
`timescale 1ns/10ps
`default_nettype none

// Operation
// - quiet start: pull wire low one clock, then release, never drive high
// - no start frame while a cycle runs; idle only from stop to start
// - quiet mode: a level change starts a cycle unless the running one carries it
// - continuous mode: only the host starts; slaves stay passive
// - mode changes only during a stop frame
// - after reset assume continuous mode and wait for the host
// - measure every stop pulse width to pick the next mode
// - stop low two clocks means quiet, three means continuous
// - next start no earlier than second clock after stop rising edge
// - count three-clock frames from start rising edge: sample, recovery, turnaround
// - sample phase: pull low exactly when the last level is low
// - recovery phase: drive high only after pulling low in sample phase
// - turnaround phase: leave the wire released
// - report levels whoever started the cycle
// - frame n sample at clock 3n-1; frames 2..16 carry irq 1..15
// - frame 3 carries irq 2 or the management interrupt
// - frame 14 carries irq 13
// - enable bit 6 gates management irq to frame, bit 7 to its pin
// - a level change reaches the host within 96 clocks
// - drive and sample the wire on the rising bus clock edge
// - in reset the wire is released; then idle continuous mode
module sirq_slave
    import sirq_pkg::*;
(
    input  wire logic          mclk,
    input  wire logic          rst,
    input  wire logic          sirq_in,
    input  wire logic [15:1]   irq_level,
    input  wire logic          system_mgmt_interrupt_n,
    input  wire sirq_smi_en2_t smi_en2,
    output logic               sirq_out,
    output logic               sirq_oe,
    output logic               system_mgmt_irq_out_n,
    output logic               quiet_mode
);

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic sirq_phase_t next_phase(input sirq_phase_t ph);
        sirq_phase_t r;
        r = PH_SAMPLE;
        unique case (ph)
            PH_SAMPLE: r = PH_RECOV;
            PH_RECOV:  r = PH_TURN;
            PH_TURN:   r = PH_SAMPLE;
            default:   r = PH_SAMPLE;
        endcase
        return r;
    endfunction

    // frame f reports level bit f-1
    function automatic logic [3:0] frame_bit(input logic [5:0] f);
        logic [5:0] d;
        d = f - 6'h01;
        return d[3:0];
    endfunction

    function automatic logic in_range(input logic [5:0] f);
        return (f >= SIRQ_FRAME_FIRST) && (f <= SIRQ_FRAME_LAST);
    endfunction

    // ************************************************************
    // state
    // ************************************************************
    sirq_state_t st_ff;
    sirq_state_t nxt_st;
    sirq_phase_t ph_ff;
    sirq_phase_t nxt_ph;
    logic [5:0]  frm_ff;
    logic [5:0]  nxt_frm;
    logic [2:0]  low_ff;
    logic [2:0]  nxt_low;
    logic        quiet_ff;
    logic        nxt_quiet;
    logic        oe_ff;
    logic        out_ff;
    logic        nxt_oe;
    logic        nxt_out;
    logic        drove_ff;
    logic        nxt_drove;
    logic [15:0] lvl_ff;
    logic [15:0] nxt_lvl;
    logic [15:0] last_ff;
    logic [15:0] nxt_last;
    logic        smi_pin_ff;

    // ************************************************************
    // level capture and frame 3 source
    // ************************************************************
    wire smi_to_frame = system_mgmt_interrupt_n | ~smi_en2.serial_en;
    // irq 2 and the management interrupt share frame 3; both low-true,
    // so a low on irq 2, or on the management one while serial_en is set, reports low there
    wire irq2_val     = irq_level[2] & smi_to_frame;
    // bit k feeds frame k+1, so irq 13 lands in frame 14
    assign nxt_lvl = {irq_level[15:3], irq2_val, irq_level[1], 1'b1};

    // ************************************************************
    // cycle tracking
    // ************************************************************
    wire line_low   = ~sirq_in;
    wire st_idle    = (st_ff == ST_IDLE);
    wire st_start   = (st_ff == ST_START);
    wire st_frame   = (st_ff == ST_FRAME);
    wire st_stop    = (st_ff == ST_STOP);
    wire st_post    = (st_ff == ST_POST);

    // any agent's start is followed, ours or not
    wire start_seen = (st_idle | st_post) & line_low;
    wire start_rise = st_start & sirq_in;
    // a data low lasts one clock; a second low in a row is the stop
    wire stop_seen  = st_frame & line_low & (low_ff == 3'h1);
    wire stop_end   = st_stop & sirq_in;

    assign nxt_st = start_seen ? ST_START :
                    start_rise ? ST_FRAME :
                    stop_seen  ? ST_STOP  :
                    stop_end   ? ST_POST  :
                    st_post    ? ST_IDLE  : st_ff;

    // start rising edge is clock 0, next clock is frame 0 turnaround
    assign nxt_ph  = start_rise ? PH_TURN :
                     st_frame   ? next_phase(ph_ff) : ph_ff;

    wire frm_step  = st_frame & (ph_ff == PH_TURN) & (frm_ff != SIRQ_FRAME_MAX);
    assign nxt_frm = start_rise ? 6'h00 :
                     frm_step   ? frm_ff + 6'h01 : frm_ff;

    wire [2:0] low_inc = (low_ff == SIRQ_LOW_MAX) ? low_ff : low_ff + 3'h1;
    assign nxt_low = line_low ? low_inc : 3'h0;

    // mode is only rewritten at the end of a stop pulse
    assign nxt_quiet = stop_end ? (low_ff == SIRQ_STOP_QUIET) : quiet_ff;

    // ************************************************************
    // wire drive
    // ************************************************************
    wire        in_cycle  = (nxt_st == ST_FRAME);
    wire        in_slot   = in_cycle & in_range(nxt_frm);
    wire [3:0]  slot_idx  = frame_bit(nxt_frm);
    wire        slot_val  = lvl_ff[slot_idx];
    wire        slot_upd  = in_slot & (nxt_ph == PH_SAMPLE);
    wire        drv_samp  = slot_upd & ~slot_val;
    wire        drv_recov = in_cycle & (nxt_ph == PH_RECOV) & drove_ff;

    // pending means a level differs from what the host last saw; a change
    // still ahead of its slot rides the running cycle, later ones retrigger
    wire        pending   = |(lvl_ff ^ last_ff);
    // post state is clock 1 after the stop edge, so the pull lands on clock 2;
    // continuous mode blocks this, keeping the slave passive
    wire        drv_start = quiet_ff & pending & sirq_in
                          & (st_idle | st_post) & ~oe_ff;

    // turnaround and every other clock fall through to released
    assign nxt_oe    = drv_samp | drv_recov | drv_start;
    assign nxt_out   = drv_recov;
    assign nxt_drove = drv_samp;

    wire [15:0] upd_mask = 16'h0001 << slot_idx;
    assign nxt_last = slot_upd ? ((last_ff & ~upd_mask) | (slot_val ? upd_mask : 16'h0000))
                               : last_ff;

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_ff    <= ST_IDLE;
            ph_ff    <= PH_TURN;
            frm_ff   <= 6'h00;
            low_ff   <= 3'h0;
            quiet_ff <= SIRQ_RST_QUIET;
            oe_ff    <= 1'b0;
            out_ff   <= 1'b1;
            drove_ff <= 1'b0;
        end else begin
            st_ff    <= nxt_st;
            ph_ff    <= nxt_ph;
            frm_ff   <= nxt_frm;
            low_ff   <= nxt_low;
            quiet_ff <= nxt_quiet;
            oe_ff    <= nxt_oe;
            out_ff   <= nxt_out;
            drove_ff <= nxt_drove;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            lvl_ff     <= SIRQ_RST_LEVEL;
            last_ff    <= SIRQ_RST_LEVEL;
            smi_pin_ff <= 1'b1;
        end else begin
            lvl_ff     <= nxt_lvl;
            last_ff    <= nxt_last;
            smi_pin_ff <= system_mgmt_interrupt_n | ~smi_en2.pin_en;
        end
    end

    assign sirq_out              = out_ff;
    assign sirq_oe               = oe_ff;
    assign system_mgmt_irq_out_n = smi_pin_ff;
    assign quiet_mode            = quiet_ff;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    chk_start_one_clk: assert property (
        oe_ff && !out_ff && (st_ff == ST_IDLE || st_ff == ST_POST) |=> !oe_ff)
        else $error("start pull lasted more than one clock");

    chk_quiet_in_active: assert property (
        (st_ff == ST_START || st_ff == ST_STOP) |-> !oe_ff)
        else $error("wire driven during start or stop frame");

    chk_cont_passive: assert property (
        !quiet_ff && (st_ff == ST_IDLE || st_ff == ST_POST) |-> !oe_ff)
        else $error("slave drove wire outside cycle in continuous mode");

    chk_mode_hold: assert property (
        $changed(quiet_ff) |-> $past(st_ff) == ST_STOP)
        else $error("mode changed outside stop frame");

    chk_stop_width: assert property (
        st_ff == ST_STOP && sirq_in |=> quiet_ff == ($past(low_ff) == 3'h2))
        else $error("mode does not match stop width");

    chk_recovery: assert property (
        st_ff == ST_FRAME && oe_ff && !out_ff |=> oe_ff && out_ff ##1 !oe_ff)
        else $error("recovery or turnaround drive wrong");

    chk_sample_drive: assert property (
        st_ff == ST_FRAME && ph_ff == PH_SAMPLE && in_range(frm_ff)
        |-> oe_ff == !last_ff[frame_bit(frm_ff)])
        else $error("sample drive does not follow level");

    chk_sample_clock: assert property (
        st_ff == ST_START && sirq_in |-> ##5 (ph_ff == PH_SAMPLE && frm_ff == 6'h02))
        else $error("frame 2 sample not five clocks after start edge");

    chk_smi_pin: assert property (
        ##1 system_mgmt_irq_out_n == $past(system_mgmt_interrupt_n | ~smi_en2.pin_en))
        else $error("management pin gating wrong");

    chk_turn_release: assert property (
        st_ff == ST_FRAME && ph_ff == PH_TURN |-> !oe_ff)
        else $error("wire driven in turnaround");

    chk_unused_frame: assert property (
        st_ff == ST_FRAME && ph_ff == PH_SAMPLE && !in_range(frm_ff)
        |-> !oe_ff)
        else $error("wire driven in an unused frame");

    chk_high_recovery: assert property (
        oe_ff && out_ff |-> st_ff == ST_FRAME && ph_ff == PH_RECOV)
        else $error("wire driven high outside recovery");

    chk_quiet_start: assert property (
        st_ff == ST_IDLE && quiet_ff && pending && sirq_in && !oe_ff
        |=> oe_ff && !out_ff)
        else $error("pending change did not start a cycle");

    chk_start_edge: assert property (
        st_ff == ST_START && sirq_in
        |=> st_ff == ST_FRAME && ph_ff == PH_TURN && frm_ff == 6'h00)
        else $error("frame count not restarted at start edge");

    chk_stop_gap: assert property (
        st_ff == ST_STOP && sirq_in |=> !oe_ff)
        else $error("start pull in the first clock after stop");

    chk_frame_step: assert property (
        st_ff == ST_FRAME && ph_ff == PH_TURN && sirq_in && frm_ff != SIRQ_FRAME_MAX
        |=> ph_ff == PH_SAMPLE && frm_ff == $past(frm_ff) + 6'h01)
        else $error("frame count did not advance after turnaround");

    // pairing is held against the pins two clocks back: one clock to
    // capture the level, one to register the drive
    chk_irq13_slot: assert property (
        st_ff == ST_FRAME && ph_ff == PH_SAMPLE && frm_ff == 6'h0E
        |-> oe_ff == !$past(irq_level[13], 2))
        else $error("frame 14 does not carry irq 13");

    chk_frame3_src: assert property (
        st_ff == ST_FRAME && ph_ff == PH_SAMPLE && frm_ff == 6'h03
        |-> oe_ff == !$past(irq_level[2] & (system_mgmt_interrupt_n | ~smi_en2.serial_en), 2))
        else $error("frame 3 source or gating wrong");

endmodule

`default_nettype wire

// >>> verif/sirq_host_model.sv
/*
 * sirq_host_model: behavioural host controller on the serial interrupt wire.
 * assumes: the bench resolves the open-drain wire with a pull-up and feeds it back as sirq_in.
 */
`timescale 1ns/10ps
`default_nettype none

module sirq_host_model (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        sirq_in,
    input  wire logic        go,
    input  wire logic [3:0]  start_len,
    input  wire logic [3:0]  stop_len,
    output logic             host_out,
    output logic             host_oe,
    output logic             busy,
    output logic             by_slave,
    output logic [16:0]      samp
);
    initial begin
        host_out = 1'b1;
        host_oe  = 1'b0;
        busy     = 1'b0;
        by_slave = 1'b0;
        samp     = '1;
    end

    // a low seen on the idle wire is a slave start; the host holds the rest of the pulse
    always @(posedge mclk) begin
        if (!rst && (go === 1'b1 || sirq_in === 1'b0)) begin
            run_cycle(!go);
        end
    end

    task automatic run_cycle(input logic slave);
        busy     <= 1'b1;
        by_slave <= slave;
        host_oe  <= 1'b1;
        host_out <= 1'b0;
        repeat (slave ? start_len - 4'h1 : start_len) @(posedge mclk);
        host_out <= 1'b1;
        @(posedge mclk);
        host_oe  <= 1'b0;
        // frame n is taken at the rising edge that ends clock 3n-1
        for (int n = 0; n < 17; n++) begin
            repeat (n == 0 ? 2 : 3) @(posedge mclk);
            samp[n] <= sirq_in;
        end
        // stop only once every frame is done; its width picks the next mode
        repeat (2) @(posedge mclk);
        host_oe  <= 1'b1;
        host_out <= 1'b0;
        repeat (stop_len) @(posedge mclk);
        host_out <= 1'b1;
        @(posedge mclk);
        host_oe  <= 1'b0;
        // no new start before the second clock after the stop edge
        @(posedge mclk);
        busy     <= 1'b0;
    endtask
endmodule

`default_nettype wire

// >>> verif/testbench.sv
/*
 * testbench: self-checking bench of the serial interrupt slave against a host model.
 * assumes: slave and host share mclk; the wire has a pull-up and no other agent.
 */
`timescale 1ns/10ps
`default_nettype none

module testbench;
    import sirq_pkg::*;
    logic          mclk, rst, go, mgmt_n, sirq_wire, sirq_out, sirq_oe, mgmt_out_n, quiet_mode;
    logic          host_out, host_oe, busy, by_slave;
    logic [15:1]   irq_level;
    logic [3:0]    start_len, stop_len;
    logic [16:0]   samp;
    sirq_smi_en2_t smi_en2;
    int            fails, n_compared, cycles;

    // ************************************************************
    // clock, wire, instances
    // ************************************************************
    initial mclk = 1'b0;
    always #50 mclk = ~mclk;
    assign sirq_wire = ((host_oe && !host_out) || (sirq_oe && !sirq_out)) ? 1'b0 : 1'b1;

    sirq_slave sirq_slave_i (
        .mclk                    (mclk),
        .rst                     (rst),
        .sirq_in                 (sirq_wire),
        .irq_level               (irq_level),
        .system_mgmt_interrupt_n (mgmt_n),
        .smi_en2                 (smi_en2),
        .sirq_out                (sirq_out),
        .sirq_oe                 (sirq_oe),
        .system_mgmt_irq_out_n   (mgmt_out_n),
        .quiet_mode              (quiet_mode)
    );
    sirq_host_model sirq_host_model_i (
        .mclk      (mclk),
        .rst       (rst),
        .sirq_in   (sirq_wire),
        .go        (go),
        .start_len (start_len),
        .stop_len  (stop_len),
        .host_out  (host_out),
        .host_oe   (host_oe),
        .busy      (busy),
        .by_slave  (by_slave),
        .samp      (samp)
    );

    // the whole run needs some 460 clocks; a hang ends here
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            end_of_test();
        end
    end

    // ************************************************************
    // helpers
    // ************************************************************
    task automatic check(input string what, input logic [16:0] seen, input logic [16:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // frame 1 and 17 carry nothing; frame 3 shares irq 2 with the gated management interrupt
    function automatic logic [16:0] frames();
        return {1'b1, irq_level[15:3], irq_level[2] & (mgmt_n | ~smi_en2.serial_en), irq_level[1], 1'b1};
    endfunction

    task automatic host_cycle(input logic [3:0] len, input logic [3:0] stop);
        start_len <= len;
        stop_len  <= stop;
        go        <= 1'b1;
        while (busy !== 1'b1) @(posedge mclk);
        go        <= 1'b0;
        while (busy !== 1'b0) @(posedge mclk);
    endtask

    task automatic idle_watch(input string what);
        logic seen;
        seen = 1'b0;
        repeat (120) begin
            @(posedge mclk);
            seen |= (busy === 1'b1) | (sirq_oe === 1'b1);
        end
        check(what, seen, 17'h0);
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_reset();
        check("oe in reset", sirq_oe, 17'h0);
        check("mode in reset", quiet_mode, 17'h0);
        check("mgmt pin in reset", mgmt_out_n, 17'h1);
        rst       <= 1'b0;
        irq_level <= 15'h7FEF;
        idle_watch("no slave start after reset");
        $display("test reset done");
    endtask

    task automatic t_cont();
        irq_level <= 15'h6A5B;
        mgmt_n    <= 1'b0;
        smi_en2   <= 8'h40;
        host_cycle(4'h4, 4'h3);
        check("frames host start", samp, frames());
        check("mode after wide stop", quiet_mode, 17'h0);
        $display("test continuous done");
    endtask

    task automatic t_quiet();
        int n;
        smi_en2 <= 8'h00;
        host_cycle(4'h8, 4'h2);
        check("frames gate off", samp, frames());
        check("mode after narrow stop", quiet_mode, 17'h1);
        // the slave's own cycle ends with a wide stop to return to continuous mode
        stop_len     <= 4'h3;
        irq_level[5] <= 1'b0;
        n = 0;
        while (busy !== 1'b1) begin
            @(posedge mclk);
            n++;
        end
        check("slave start delay", n <= 6, 17'h1);
        while (busy !== 1'b0) @(posedge mclk);
        check("slave started", by_slave, 17'h1);
        check("frames slave start", samp, frames());
        check("mode back", quiet_mode, 17'h0);
        irq_level[5] <= 1'b1;
        idle_watch("no start in continuous");
        $display("test quiet done");
    endtask

    task automatic t_pin();
        smi_en2 <= 8'h80;
        repeat (3) @(posedge mclk);
        check("mgmt pin low", mgmt_out_n, 17'h0);
        mgmt_n  <= 1'b1;
        repeat (3) @(posedge mclk);
        check("mgmt pin high", mgmt_out_n, 17'h1);
        mgmt_n  <= 1'b0;
        smi_en2 <= 8'h40;
        repeat (3) @(posedge mclk);
        check("mgmt pin gated", mgmt_out_n, 17'h1);
        $display("test pin done");
    endtask

    initial begin
        rst        = 1'b1;
        go         = 1'b0;
        mgmt_n     = 1'b1;
        irq_level  = '1;
        start_len  = 4'h4;
        stop_len   = 4'h3;
        smi_en2    = 8'h00;
        fails      = 0;
        n_compared = 0;
        cycles     = 0;
        repeat (10) @(posedge mclk);
        t_reset();
        t_cont();
        t_quiet();
        t_pin();
        end_of_test();
    end
endmodule

`default_nettype wire
